// ==== bench/asicg_assertions.sv ====
// assertion checker on the clock generator ports
`timescale 1ns/1ns
`include "asicg_cfg.svh"
module asicg_chk (
   input wire logic mclk, nrst, wr, rd, // clock, reset, strobes
   input wire logic [7:0] addr, wdata, rdata, // register bus
   input wire logic p_bclk_out, p_bclk_oe, p_fsync_out, p_fsync_oe, // primary pins
   input wire logic s_bclk_oe, s_fsync_out, rate_family_select // secondary pins, family
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_cfg_wr;
      wr && addr == `ASICG_ADR_CLK_CFG;
   endsequence
   sequence s_err_rd;
      rd && addr == `ASICG_ADR_ERR;
   endsequence
   AST_FAMILY: assert property (s_cfg_wr |-> ##2 rate_family_select == $past(wdata[0], 2))
      else $error("family select wrong");
   AST_P_OE: assert property (s_cfg_wr |-> ##2 p_bclk_oe == $past(wdata[4], 2))
      else $error("primary enable wrong");
   AST_S_OE: assert property (s_cfg_wr |-> ##2 s_bclk_oe == $past(wdata[3], 2))
      else $error("secondary enable wrong");
   AST_P_IDLE: assert property (!p_bclk_oe && !$past(p_bclk_oe) |-> !p_bclk_out && !p_fsync_out)
      else $error("primary driven as target");
   AST_P_FS_OE: assert property (p_fsync_out |-> p_fsync_oe || $past(p_fsync_oe))
      else $error("frame sync without enable");
   AST_P_PULSE: assert property (p_fsync_out |=> !p_fsync_out)
      else $error("primary sync too long");
   AST_S_PULSE: assert property (s_fsync_out |=> !s_fsync_out)
      else $error("secondary sync too long");
   AST_ERR_RSVD: assert property (s_err_rd |=> rdata[6:5] == 2'b00 && !rdata[0])
      else $error("reserved status bit set");
endmodule
bind asicg_top asicg_chk u_chk (.mclk, .nrst, .wr, .rd, .addr, .wdata, .rdata, .p_bclk_out, .p_bclk_oe,
   .p_fsync_out, .p_fsync_oe, .s_bclk_oe, .s_fsync_out, .rate_family_select);

// ==== bench/asicg_host.sv ====
// host model: external bit clock and frame sync, still while run is low
`timescale 1ns/1ns
module asicg_host #(
   parameter int unsigned RATIO = 4
) (
   input wire logic run, // frames in progress
   output logic bclk,    // external bit clock
   output logic fsync    // frame sync
);
   int unsigned n;
   initial begin
      n = 0;
      bclk = 1'b0;
      fsync = 1'b0;
      forever begin
         if (!run) begin
            // idle link: frame sync low, next frame starts from its first bit
            fsync = 1'b0;
            n = 0;
            wait (run);
         end
         #62 bclk = 1'b1;
         #63 bclk = 1'b0;
         fsync = (n == 0);
         n = (n + 1) % RATIO;
      end
   end
endmodule

// ==== bench/test_asi_controller_clock_gen_and_errors.sv ====
// self-checking bench of the clock generator
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("mismatch %0t got %h", $time, g); end end
module test_asi_controller_clock_gen_and_errors;
   logic mclk = 0, nrst = 0, wr = 0, rd = 0, ibclk = 0, audio_clk = 0, arun = 1, hrun = 0, hbclk, hfs;
   logic [7:0] addr = 0, wdata = 0, rdata;
   logic [3:0] ebad = 0;
   logic irq, p_bclk_out, p_bclk_oe, p_fsync_out, p_fsync_oe, s_bclk_out, s_bclk_oe, s_fsync_out, s_fsync_oe;
   logic rate_family_select;
   wire logic p_bclk_ext = hbclk, s_bclk_ext = hbclk, p_fsync_in = hfs, s_fsync_in = hfs;
   wire logic p_bclk_int = ibclk, s_bclk_int = ibclk;
   wire logic src_ratio_bad = ebad[3], src_custom_ratio = ebad[2], dem_rate_bad = ebad[1], mic_clk_bad = ebad[0];
   int bad_count = 0, n_checks = 0;
   logic [3:0] cs [4] = '{4'h8, 4'hC, 4'h2, 4'h1};
   logic [7:0] ex [4] = '{8'h10, 8'h00, 8'h08, 8'h04};
   always #5 mclk = ~mclk;
   always begin
      #62 ibclk = 1'b1;
      #63 ibclk = 1'b0;
   end
   always #20 if (arun) audio_clk = ~audio_clk;
   asicg_host #(.RATIO(4)) host (.run(hrun), .bclk(hbclk), .fsync(hfs));
   asicg_top #(.STOP_CYCLES(50)) DUT (.*);
   task automatic wreg(input logic [7:0] a, d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, e);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask
   // time between two frame pulses, within 15 ns (one and a half system clocks) of jitter
   task automatic gap(input bit sec, input time e);
      time t [2];
      for (int i = 0; i < 2; i++) begin
         for (int k = 0; k < 8000 && !(sec ? s_fsync_out : p_fsync_out); k++) begin
            @(posedge mclk);
            #1;
         end
         t[i] = $time;
         @(posedge mclk);
         #1;
      end
      `CHK((t[1] - t[0] > e - 15) && (t[1] - t[0] < e + 15), 1'b1)
   endtask
   task automatic t_regs();
      rchk(8'h37, 8'h20);
      rchk(8'h3C, 8'h00);
      rchk(8'h50, 8'h00);
      wreg(8'h37, 8'hF9);
      rchk(8'h37, 8'hF9);
      `CHK({rate_family_select, p_bclk_oe, s_bclk_oe}, 3'b111)
      `CHK({p_fsync_oe, s_fsync_oe}, 2'b11)
      wreg(8'h37, 8'h18);
      wreg(8'h38, 8'hBF);
      rchk(8'h38, 8'hBF);
      `CHK(rate_family_select, 1'b0)
   endtask
   task automatic t_frames();
      wreg(8'h38, 8'h80);
      wreg(8'h39, 8'h04);
      gap(0, 500);
      wreg(8'h38, 8'hC0);
      gap(0, 500);
      hrun <= 1'b1;
      wreg(8'h3A, 8'h01);
      wreg(8'h3B, 8'h00);
      gap(1, 32000);
      wreg(8'h3A, 8'h41);
      gap(1, 32000);
      hrun <= 1'b0;
      wreg(8'h39, 8'h00);
      repeat (30) @(posedge mclk);
      rchk(8'h3C, 8'h80);
      wreg(8'h39, 8'h04);
      repeat (30) @(posedge mclk);
      rchk(8'h3C, 8'h00);
   endtask
   task automatic t_flags();
      wreg(8'h41, 8'h00);
      for (int i = 0; i < 4; i++) begin
         ebad <= cs[i];
         rchk(8'h3C, ex[i]);
      end
      ebad <= 4'h0;
      `CHK(irq, 1'b0)
      wreg(8'h41, 8'h1C);
      repeat (2) @(posedge mclk);
      #1;
      `CHK(irq, 1'b1)
      rchk(8'h40, 8'h9C);
      wreg(8'h40, 8'h9C);
      repeat (2) @(posedge mclk);
      #1;
      `CHK(irq, 1'b0)
   endtask
   task automatic t_stop();
      arun <= 1'b0;
      repeat (40) @(posedge mclk);
      rchk(8'h3C, 8'h00);
      repeat (20) @(posedge mclk);
      rchk(8'h3C, 8'h02);
      arun <= 1'b1;
      repeat (10) @(posedge mclk);
      rchk(8'h3C, 8'h00);
   endtask
   task automatic summarize();
      if (bad_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #400000;
      bad_count++;
      summarize();
   end
   initial begin
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      t_regs();
      t_frames();
      t_flags();
      t_stop();
      summarize();
   end
endmodule

// ==== logic/asicg_cfg.svh ====
// register map, field positions, reset values and timing counts of the clock generator
`ifndef ASICG_CFG_SVH
`define ASICG_CFG_SVH
`define ASICG_ADR_CLK_CFG 8'h37
`define ASICG_ADR_P_HI 8'h38
`define ASICG_ADR_P_LO 8'h39
`define ASICG_ADR_S_HI 8'h3A
`define ASICG_ADR_S_LO 8'h3B
`define ASICG_ADR_ERR 8'h3C
`define ASICG_ADR_IRQ_STS 8'h40
`define ASICG_ADR_IRQ_MSK 8'h41
`define ASICG_RST_CLK_CFG 8'h20
`define ASICG_RST_ZERO 8'h00
`define ASICG_CLK_CFG_MASK 8'hF9
`define ASICG_ERR_MASK 8'h9E
`define ASICG_B_INT 7
`define ASICG_B_INV 6
`define ASICG_B_PCTL 4
`define ASICG_B_SCTL 3
`define ASICG_B_FAM 0
`define ASICG_B_FSERR 7
`define ASICG_B_SRC 4
`define ASICG_B_DEM 3
`define ASICG_B_PDM 2
`define ASICG_B_STOP 1
`define ASICG_STOP_NS 1000000
`define ASICG_MCLK_NS 10
`define ASICG_STOP_CYC (`ASICG_STOP_NS / `ASICG_MCLK_NS)
`endif

// ==== logic/asicg_pkg.sv ====
// types of the clock generator
package asicg_pkg;
   typedef logic [7:0] asicg_byte_t;
   typedef logic [13:0] asicg_ratio_t;
   typedef struct packed {
      logic [2:0] sync;
      logic prev;
      logic [13:0] cnt;
      logic fs;
      logic bclk;
      logic seen;
      logic err;
   } asicg_port_s;
endpackage

// ==== logic/asicg_top.sv ====
// controller clock generation and clock error status for two serial ports
`timescale 1ns/1ns
`include "asicg_cfg.svh"
module asicg_top #(
   parameter int unsigned STOP_CYCLES = `ASICG_STOP_CYC
) (
   input wire logic mclk,             // 100 MHz system clock
   input wire logic nrst,             // async reset, active low
   input wire logic [7:0] addr,       // register address
   input wire logic [7:0] wdata,      // write data
   input wire logic wr,               // write strobe
   input wire logic rd,               // read strobe
   output logic [7:0] rdata,          // read data, cycle after rd
   output logic irq,                  // level interrupt
   input wire logic p_bclk_ext,       // primary external bit clock
   input wire logic p_bclk_int,       // primary internal bit clock
   input wire logic p_fsync_in,       // primary frame sync from host
   input wire logic s_bclk_ext,       // secondary external bit clock
   input wire logic s_bclk_int,       // secondary internal bit clock
   input wire logic s_fsync_in,       // secondary frame sync from host
   input wire logic audio_clk,        // audio clock source
   input wire logic src_ratio_bad,    // converter ratio unsupported
   input wire logic src_custom_ratio, // custom m/n ratio in use
   input wire logic dem_rate_bad,     // element matching rate invalid
   input wire logic mic_clk_bad,      // mic clock cannot be made
   output logic p_bclk_out,           // primary bit clock out
   output logic p_bclk_oe,            // primary bit clock drive enable
   output logic p_fsync_out,          // primary frame sync out
   output logic p_fsync_oe,           // primary frame sync drive enable
   output logic s_bclk_out,           // secondary bit clock out
   output logic s_bclk_oe,            // secondary bit clock drive enable
   output logic s_fsync_out,          // secondary frame sync out
   output logic s_fsync_oe,           // secondary frame sync drive enable
   output logic rate_family_select    // 0: 48 kHz family, 1: 44.1 kHz
);
   typedef struct packed {
      asicg_pkg::asicg_byte_t clk_cfg;
      asicg_pkg::asicg_byte_t p_hi;
      asicg_pkg::asicg_byte_t p_lo;
      asicg_pkg::asicg_byte_t s_hi;
      asicg_pkg::asicg_byte_t s_lo;
      asicg_pkg::asicg_byte_t irq_sts;
      asicg_pkg::asicg_byte_t irq_msk;
      asicg_pkg::asicg_byte_t err_prev;
      asicg_pkg::asicg_byte_t rdata;
      logic irq;
      asicg_pkg::asicg_port_s p;
      asicg_pkg::asicg_port_s s;
      logic [2:0] a_sync;
      logic [19:0] stop_cnt;
      logic stopped;
      logic [1:0] oe;
      logic fam;
   } asicg_st_s;

   asicg_st_s st_q, st_d;
   logic [5:0] raw_q;

   // async inputs: the first stage here feeds only the second
   logic [5:0] raw_a_q, raw_b_q;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         raw_a_q <= 6'h00;
         raw_b_q <= 6'h00;
      end else begin
         raw_a_q <= {p_bclk_ext, p_bclk_int, p_fsync_in, s_bclk_ext, s_bclk_int, s_fsync_in};
         raw_b_q <= raw_a_q;
      end
   end
   assign raw_q = raw_b_q;

   function automatic asicg_pkg::asicg_port_s port_step(
      input asicg_pkg::asicg_port_s cur,
      input logic bext,
      input logic bint,
      input logic fsin,
      input asicg_pkg::asicg_byte_t hi,
      input asicg_pkg::asicg_byte_t lo,
      input logic ctl
   );
      asicg_pkg::asicg_port_s nx;
      asicg_pkg::asicg_ratio_t ratio;
      logic src;
      logic rise;
      nx = cur;
      ratio = {hi[5:0], lo};
      src = hi[`ASICG_B_INT] ? bint : bext;
      src = src ^ hi[`ASICG_B_INV];
      nx.bclk = ctl ? bint : 1'b0;                                  // output clock stays uninverted
      nx.prev = src;
      rise = src & ~cur.prev;
      nx.fs = 1'b0;
      if (rise) begin
         if (ctl) begin
            // controller: frame sync pulse every ratio bit clocks
            if (ratio != 14'h0000 && cur.cnt >= ratio - 14'h0001) begin
               nx.cnt = 14'h0000;
               nx.fs = 1'b1;
            end else begin
               nx.cnt = cur.cnt + 14'h0001;
            end
            nx.err = (ratio == 14'h0000);
         end else begin
            // target: check host frame length against the ratio
            nx.sync = {cur.sync[1:0], fsin};
            if (fsin && !cur.sync[0]) begin
               nx.err = cur.seen && ratio != 14'h0000 && (cur.cnt + 14'h0001 != ratio);
               nx.seen = 1'b1;
               nx.cnt = 14'h0000;
            end else begin
               nx.cnt = cur.cnt + 14'h0001;
            end
         end
      end
      return nx;
   endfunction

   asicg_pkg::asicg_byte_t err_now;
   always_comb begin
      st_d = st_q;
      st_d.p = port_step(st_q.p, raw_q[5], raw_q[4], raw_q[3], st_q.p_hi, st_q.p_lo,
                         st_q.clk_cfg[`ASICG_B_PCTL]);
      st_d.s = port_step(st_q.s, raw_q[2], raw_q[1], raw_q[0], st_q.s_hi, st_q.s_lo,
                         st_q.clk_cfg[`ASICG_B_SCTL]);
      st_d.oe = {st_q.clk_cfg[`ASICG_B_PCTL], st_q.clk_cfg[`ASICG_B_SCTL]};
      st_d.fam = st_q.clk_cfg[`ASICG_B_FAM];
      // audio clock stop watchdog
      st_d.a_sync = {st_q.a_sync[1:0], audio_clk};
      if (st_q.a_sync[2] != st_q.a_sync[1]) begin
         st_d.stop_cnt = 20'h00000;
         st_d.stopped = 1'b0;
      end else if (st_q.stop_cnt >= 20'(STOP_CYCLES - 1)) begin
         st_d.stopped = 1'b1;
      end else begin
         st_d.stop_cnt = st_q.stop_cnt + 20'h00001;
      end
      err_now = 8'h00;
      err_now[`ASICG_B_FSERR] = st_q.p.err | st_q.s.err;
      err_now[`ASICG_B_SRC] = src_ratio_bad & ~src_custom_ratio;
      err_now[`ASICG_B_DEM] = dem_rate_bad;
      err_now[`ASICG_B_PDM] = mic_clk_bad;
      err_now[`ASICG_B_STOP] = st_q.stopped;
      st_d.err_prev = err_now;
      // write one clears; new rising events win over the clear
      if (wr && addr == `ASICG_ADR_IRQ_STS) begin
         st_d.irq_sts = st_q.irq_sts & ~wdata;
      end
      st_d.irq_sts = (st_d.irq_sts | (err_now & ~st_q.err_prev)) & `ASICG_ERR_MASK;
      if (wr) begin
         case (addr)
            `ASICG_ADR_CLK_CFG: st_d.clk_cfg = wdata & `ASICG_CLK_CFG_MASK;
            `ASICG_ADR_P_HI: st_d.p_hi = wdata;
            `ASICG_ADR_P_LO: st_d.p_lo = wdata;
            `ASICG_ADR_S_HI: st_d.s_hi = wdata;
            `ASICG_ADR_S_LO: st_d.s_lo = wdata;
            `ASICG_ADR_IRQ_MSK: st_d.irq_msk = wdata & `ASICG_ERR_MASK;
            default: ;
         endcase
      end
      st_d.rdata = 8'h00;
      if (rd) begin
         case (addr)
            `ASICG_ADR_CLK_CFG: st_d.rdata = st_q.clk_cfg;
            `ASICG_ADR_P_HI: st_d.rdata = st_q.p_hi;
            `ASICG_ADR_P_LO: st_d.rdata = st_q.p_lo;
            `ASICG_ADR_S_HI: st_d.rdata = st_q.s_hi;
            `ASICG_ADR_S_LO: st_d.rdata = st_q.s_lo;
            `ASICG_ADR_ERR: st_d.rdata = err_now;
            `ASICG_ADR_IRQ_STS: st_d.rdata = st_q.irq_sts;
            `ASICG_ADR_IRQ_MSK: st_d.rdata = st_q.irq_msk;
            default: st_d.rdata = 8'h00;
         endcase
      end
      st_d.irq = |(st_d.irq_sts & st_d.irq_msk);
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_q <= '0;
         st_q.clk_cfg <= `ASICG_RST_CLK_CFG;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata = st_q.rdata;
   assign irq = st_q.irq;
   assign p_bclk_out = st_q.p.bclk;
   assign p_fsync_out = st_q.p.fs;
   assign p_bclk_oe = st_q.oe[1];
   assign p_fsync_oe = st_q.oe[1];
   assign s_bclk_out = st_q.s.bclk;
   assign s_fsync_out = st_q.s.fs;
   assign s_bclk_oe = st_q.oe[0];
   assign s_fsync_oe = st_q.oe[0];
   assign rate_family_select = st_q.fam;
endmodule
